// [esagg_defines.vh]
// constants for the event status aggregator
`ifndef ESAGG_DEFINES_VH
`define ESAGG_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ESAGG_ADDR_STATUS   8'h00
`define ESAGG_ADDR_SRC1     8'h01
`define ESAGG_ADDR_SRC2     8'h02
`define ESAGG_ADDR_TILT     8'h03
`define ESAGG_ADDR_CFG      8'h04
`define ESAGG_ADDR_IRQ_STAT 8'h05
`define ESAGG_ADDR_IRQ_MASK 8'h06
`define ESAGG_ADDR_ROUTE    8'h07

// ----------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------
`define ESAGG_BIT_BUF       5
`define ESAGG_BIT_OT        4
`define ESAGG_BIT_WT        3
`define ESAGG_BIT_TILT      2

// ----------------------------------------------------------------------
// config fields and reset values
// ----------------------------------------------------------------------
`define ESAGG_CFG_MODE_LSB  0
`define ESAGG_CFG_OT_LE     2
`define ESAGG_CFG_WT_LE     3
`define ESAGG_MODE_OFF      2'h0
`define ESAGG_MODE_TRIG     2'h3
`define ESAGG_CFG_RST       8'h00
`define ESAGG_MASK_RST      8'h00
`define ESAGG_ROUTE_RST     8'h00

`endif

// [esagg_latch_bit.v]
// one event bit with level copy or read-clear latch behaviour
`timescale 1ns/1ps
module esagg_latch_bit
(
  // clock and reset
  input  wire ref_clk_i,
  input  wire rst_n_i,
  // control
  input  wire cond_i,
  input  wire latch_en_i,
  input  wire clr_i,
  // result
  output wire bit_o
);
  reg bit_q;
  reg bit_d;

  // ----------------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------------
  always @*
  begin
    if (!latch_en_i)
      bit_d = cond_i;
    else if (cond_i)
      bit_d = 1'b1;
    else if (clr_i)
      bit_d = 1'b0;
    else
      bit_d = bit_q;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bit_q <= 1'b0;
    else
      bit_q <= bit_d;
  end

  assign bit_o = bit_q;
endmodule

// [esagg_buf_event.v]
// buffer event qualification
`timescale 1ns/1ps
`include "esagg_defines.vh"
module esagg_buf_event
(
  // buffer mode and flags
  input  wire [1:0] mode_i,
  input  wire       wmrk_i,
  input  wire       ovf_i,
  input  wire       gate_err_i,
  input  wire       full_i,
  // result
  output wire       event_o
);
  wire wmrk_ok;

  assign wmrk_ok = wmrk_i & (mode_i != `ESAGG_MODE_TRIG);
  assign event_o = (mode_i != `ESAGG_MODE_OFF) &
                   (wmrk_ok | ovf_i | gate_err_i | full_i);
endmodule

// [esagg_top.v]
// event status aggregator with register port and interrupt pins
`timescale 1ns/1ps
`include "esagg_defines.vh"
module esagg_top
(
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  // register port
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // buffer function flags
  input  wire       buffer_watermark_flag_i,
  input  wire       buffer_overflow_flag_i,
  input  wire       buffer_gate_error_i,
  input  wire       buffer_full_i,
  // change detector and tilt flags
  input  wire       outside_threshold_active_i,
  input  wire       within_threshold_active_i,
  input  wire       tilt_position_changed_i,
  input  wire       tilt_change_detected_i,
  // interrupt outputs
  output reg        irq_o,
  output reg        first_irq_pin_o,
  output reg        second_irq_pin_o
);
  // ----------------------------------------------------------------------
  // internal state
  // ----------------------------------------------------------------------
  reg  [7:0] cfg_q;
  reg  [7:0] cfg_d;
  reg  [7:0] mask_q;
  reg  [7:0] mask_d;
  reg  [7:0] route_q;
  reg  [7:0] route_d;
  reg  [7:0] istat_q;
  reg  [7:0] istat_d;
  reg        tilt_q;
  reg        tilt_d;
  reg  [7:0] status_q;
  wire [7:0] status_d;
  wire [7:0] status_rise;
  reg  [7:0] rdata_d;
  wire       buf_evt;
  wire       ot_bit;
  wire       wt_bit;
  wire       tilt_set;
  wire       rd_src1;
  wire       rd_src2;
  wire       rd_tilt;
  wire       wr_cfg;
  wire       wr_istat;
  wire       wr_mask;
  wire       wr_route;
  wire [7:0] pend;
  wire [7:0] pend_one;
  wire [7:0] pend_two;
  wire       irq_d;
  wire       first_pin_d;
  wire       second_pin_d;

  // ----------------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------------
  function is_rd;
    input [7:0] a;
    input [7:0] off;
    input       rd;
    begin
      is_rd = rd & (a == off);
    end
  endfunction

  function is_wr;
    input [7:0] a;
    input [7:0] off;
    input       wr;
    begin
      is_wr = wr & (a == off);
    end
  endfunction

  assign rd_src1  = is_rd(addr_i, `ESAGG_ADDR_SRC1, rd_i);
  assign rd_src2  = is_rd(addr_i, `ESAGG_ADDR_SRC2, rd_i);
  assign rd_tilt  = is_rd(addr_i, `ESAGG_ADDR_TILT, rd_i);
  assign wr_cfg   = is_wr(addr_i, `ESAGG_ADDR_CFG, wr_i);
  assign wr_istat = is_wr(addr_i, `ESAGG_ADDR_IRQ_STAT, wr_i);
  assign wr_mask  = is_wr(addr_i, `ESAGG_ADDR_IRQ_MASK, wr_i);
  assign wr_route = is_wr(addr_i, `ESAGG_ADDR_ROUTE, wr_i);

  // ----------------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------------
  esagg_buf_event u_buf
  (
    .mode_i     (cfg_q[`ESAGG_CFG_MODE_LSB+1:`ESAGG_CFG_MODE_LSB]),
    .wmrk_i     (buffer_watermark_flag_i),
    .ovf_i      (buffer_overflow_flag_i),
    .gate_err_i (buffer_gate_error_i),
    .full_i     (buffer_full_i),
    .event_o    (buf_evt)
  );

  esagg_latch_bit u_ot
  (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .cond_i     (outside_threshold_active_i),
    .latch_en_i (cfg_q[`ESAGG_CFG_OT_LE]),
    .clr_i      (rd_src1),
    .bit_o      (ot_bit)
  );

  esagg_latch_bit u_wt
  (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .cond_i     (within_threshold_active_i),
    .latch_en_i (cfg_q[`ESAGG_CFG_WT_LE]),
    .clr_i      (rd_src2),
    .bit_o      (wt_bit)
  );

  assign tilt_set = tilt_position_changed_i & tilt_change_detected_i;

  // ----------------------------------------------------------------------
  // tilt change bit, set wins over read clear
  // ----------------------------------------------------------------------
  always @*
  begin
    if (tilt_set)
      tilt_d = 1'b1;
    else if (rd_tilt)
      tilt_d = 1'b0;
    else
      tilt_d = tilt_q;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tilt_q <= 1'b0;
    else
      tilt_q <= tilt_d;
  end

  // ----------------------------------------------------------------------
  // event status register
  // ----------------------------------------------------------------------
  assign status_d    = {2'b00, buf_evt, ot_bit, wt_bit, tilt_q, 2'b00};
  assign status_rise = status_d & ~status_q;

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status_q <= 8'h00;
    else
      status_q <= status_d;
  end

  // ----------------------------------------------------------------------
  // sticky interrupt status, write one to clear
  // ----------------------------------------------------------------------
  always @*
  begin
    istat_d = istat_q;
    if (wr_istat)
      istat_d = istat_d & ~wdata_i;
    istat_d = istat_d | status_rise;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      istat_q <= 8'h00;
    else
      istat_q <= istat_d;
  end

  // ----------------------------------------------------------------------
  // config, mask and route registers
  // ----------------------------------------------------------------------
  always @*
  begin
    cfg_d = cfg_q;
    if (wr_cfg)
      cfg_d = wdata_i;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_q <= `ESAGG_CFG_RST;
    else
      cfg_q <= cfg_d;
  end

  always @*
  begin
    mask_d = mask_q;
    if (wr_mask)
      mask_d = wdata_i;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mask_q <= `ESAGG_MASK_RST;
    else
      mask_q <= mask_d;
  end

  always @*
  begin
    route_d = route_q;
    if (wr_route)
      route_d = wdata_i;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      route_q <= `ESAGG_ROUTE_RST;
    else
      route_q <= route_d;
  end

  // ----------------------------------------------------------------------
  // per-bit masking and pin routing
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_route
      assign pend[gi]     = istat_q[gi] & mask_q[gi];
      assign pend_one[gi] = pend[gi] & ~route_q[gi];
      assign pend_two[gi] = pend[gi] & route_q[gi];
    end
  endgenerate

  assign irq_d        = |pend;
  assign first_pin_d  = |pend_one;
  assign second_pin_d = |pend_two;

  // ----------------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= irq_d;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      first_irq_pin_o <= 1'b0;
    else
      first_irq_pin_o <= first_pin_d;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      second_irq_pin_o <= 1'b0;
    else
      second_irq_pin_o <= second_pin_d;
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always @*
  begin
    rdata_d = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `ESAGG_ADDR_STATUS:   rdata_d = status_q;
        `ESAGG_ADDR_SRC1:     rdata_d = {7'h00, ot_bit};
        `ESAGG_ADDR_SRC2:     rdata_d = {7'h00, wt_bit};
        `ESAGG_ADDR_TILT:     rdata_d = {7'h00, tilt_q};
        `ESAGG_ADDR_CFG:      rdata_d = cfg_q;
        `ESAGG_ADDR_IRQ_STAT: rdata_d = istat_q;
        `ESAGG_ADDR_IRQ_MASK: rdata_d = mask_q;
        `ESAGG_ADDR_ROUTE:    rdata_d = route_q;
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rdata_d;
  end
endmodule

// [esagg_monitor.sv]
// checker for the event status aggregator
`timescale 1ns/1ps
module esagg_monitor
(
  // clock and reset
  input wire       ref_clk_i,
  input wire       rst_n_i,
  // register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  // event sources
  input wire       buffer_watermark_flag_i,
  input wire       buffer_overflow_flag_i,
  input wire       buffer_gate_error_i,
  input wire       buffer_full_i,
  input wire       outside_threshold_active_i,
  input wire       within_threshold_active_i,
  input wire       tilt_position_changed_i,
  input wire       tilt_change_detected_i
);
  logic [7:0] cfg_q;
  wire        rd0  = rd_i && addr_i == 8'h00;
  wire        ot   = outside_threshold_active_i;
  wire        tilt = tilt_position_changed_i && tilt_change_detected_i;
  wire        bufe = cfg_q[1:0] != 2'h0 && (buffer_overflow_flag_i || buffer_gate_error_i
                     || buffer_full_i || (buffer_watermark_flag_i && cfg_q[1:0] != 2'h3));
  always @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      cfg_q <= 8'h00;
    else if (wr_i && addr_i == 8'h04)
      cfg_q <= wdata_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_buf_set; bufe[*4] ##0 rd0 |=> rdata_o[5]; endproperty
  a_buf_set: assert property (p_buf_set) else $error("buffer bit low");
  property p_buf_clr; (!bufe)[*4] ##0 rd0 |=> !rdata_o[5]; endproperty
  a_buf_clr: assert property (p_buf_clr) else $error("buffer bit high");
  property p_ot_copy; ot[*4] ##0 rd0 |=> rdata_o[4]; endproperty
  a_ot_copy: assert property (p_ot_copy) else $error("outside bit low");
  property p_ot_auto; (!cfg_q[2] && !ot)[*4] ##0 rd0 |=> !rdata_o[4]; endproperty
  a_ot_auto: assert property (p_ot_auto) else $error("outside bit stuck");
  property p_ot_latch;
    cfg_q[2] && ot ##1 (cfg_q[2] && !(rd_i && addr_i == 8'h01))[*4] ##0 rd0 |=> rdata_o[4];
  endproperty
  a_ot_latch: assert property (p_ot_latch) else $error("outside latch lost");
  property p_wt_copy; within_threshold_active_i[*4] ##0 rd0 |=> rdata_o[3]; endproperty
  a_wt_copy: assert property (p_wt_copy) else $error("within bit low");
  property p_tilt_set; tilt[*4] ##0 rd0 |=> rdata_o[2]; endproperty
  a_tilt_set: assert property (p_tilt_set) else $error("tilt bit low");
  property p_tilt_clr; rd_i && addr_i == 8'h03 && !tilt ##1 (!tilt)[*4] ##0 rd0 |=> !rdata_o[2];
  endproperty
  a_tilt_clr: assert property (p_tilt_clr) else $error("tilt bit not cleared");
  c_buf: cover property (rd0 ##1 rdata_o[5]);
  c_ot: cover property (rd0 ##1 rdata_o[4]);
  c_tilt: cover property (rd_i && addr_i == 8'h03 && tilt);
endmodule
bind esagg_top esagg_monitor u_mon (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .buffer_watermark_flag_i, .buffer_overflow_flag_i, .buffer_gate_error_i,
  .buffer_full_i, .outside_threshold_active_i, .within_threshold_active_i,
  .tilt_position_changed_i, .tilt_change_detected_i);

// [esagg_host_model.sv]
// host model driving the register port
`timescale 1ns/1ps
module esagg_host_model
(
  // clock
  input  wire        ref_clk_i,
  // register port
  output logic [7:0] addr_o  = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic       wr_o    = 1'b0,
  output logic       rd_o    = 1'b0
);
  logic [15:0] q[$];
  // one access, a read notes mask and expected value
  task acc(input logic w, input logic [7:0] a, d, m);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    if (!w)
      q.push_back({m, d});
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule

// [esagg_bench.sv]
// testbench for the event status aggregator
`timescale 1ns/1ps
module esagg_bench;
  logic       ref_clk_i = 0, rst_n_i = 0, seen = 0, irq_a, irq_o, wr_i, rd_i, pin_one, pin_two;
  logic [7:0] addr_i, wdata_i, rdata_o, f = 0;
  logic [1:0] md;
  logic [15:0] n;
  int         failures = 0, checks = 0;
  esagg_host_model u_host (.ref_clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
    .rd_o(rd_i));
  esagg_top u_dut (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .buffer_watermark_flag_i(f[7]), .buffer_overflow_flag_i(f[6]), .buffer_gate_error_i(f[5]),
    .buffer_full_i(f[4]), .outside_threshold_active_i(f[3]), .within_threshold_active_i(f[2]),
    .tilt_position_changed_i(f[1]), .tilt_change_detected_i(f[0]), .irq_o,
    .first_irq_pin_o(pin_one), .second_irq_pin_o(pin_two));
  always #12.5 ref_clk_i = ~ref_clk_i;
  task chk(input logic [7:0] g, e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task hold(input logic [7:0] v);
    @(posedge ref_clk_i);
    f <= v;
    repeat (5) @(posedge ref_clk_i);
  endtask
  always @(posedge ref_clk_i)
  begin
    if (seen)
    begin
      n = u_host.q.pop_front();
      chk(rdata_o & n[15:8], n[7:0]);
    end
    seen <= rd_i;
  end
  initial
  begin
    #2000000;
    failures++;
    stop_test;
  end
  initial
  begin
    void'($urandom(36259));
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (30)
    begin
      hold(8'h00);
      u_host.acc(0, 8'h03, 8'h00, 8'h00);
      md = $urandom;
      u_host.acc(1, 8'h04, {6'h00, md}, 8'h00);
      hold($urandom);
      u_host.acc(0, 8'h00, {2'b00, md != 0 && (|f[6:4] || (f[7] && md != 3)), f[3:2], &f[1:0],
        2'b00}, 8'h3C);
    end
    u_host.acc(1, 8'h04, 8'h0C, 8'h00);
    hold(8'h0C);
    u_host.acc(0, 8'h01, 8'h01, 8'h01);
    hold(8'h00);
    u_host.acc(0, 8'h00, 8'h18, 8'h18);
    u_host.acc(0, 8'h01, 8'h01, 8'h01);
    u_host.acc(0, 8'h02, 8'h01, 8'h01);
    hold(8'h00);
    u_host.acc(0, 8'h00, 8'h00, 8'h18);
    u_host.acc(1, 8'h04, 8'h00, 8'h00);
    u_host.acc(1, 8'h05, 8'hFF, 8'h00);
    hold(8'h08);
    hold(8'h00);
    u_host.acc(0, 8'h05, 8'h10, 8'h10);
    u_host.acc(1, 8'h06, 8'h00, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    irq_a = irq_o;
    u_host.acc(1, 8'h06, 8'hFF, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    chk({7'h00, irq_a ^ irq_o}, 8'h01);
    u_host.acc(1, 8'h07, 8'h10, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    chk({6'h00, pin_two, pin_one}, 8'h02);
    u_host.acc(1, 8'h07, 8'h00, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    chk({6'h00, pin_two, pin_one}, 8'h01);
    u_host.acc(1, 8'h05, 8'h10, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    chk({7'h00, irq_o}, 8'h00);
    u_host.acc(0, 8'h05, 8'h00, 8'h10);
    u_host.acc(0, 8'h08, 8'h00, 8'hFF);
    repeat (4) @(posedge ref_clk_i);
    if (u_host.q.size() != 0)
      failures++;
    stop_test;
  end
endmodule
